/* core/tcw_top.sv */
// Contract
// (RQ1) Software loads timer two, picks source, then sets run bit 3.
// (RQ2) Timer two divides its selected source by loaded value plus one.
// (RQ3) Pulse at zero sets flag, reloads, keeps counting.
// (RQ4) Software stops timer two before reading its count.
// (RQ5) Timer three has load-both and load-reload-only writes.
// (RQ6) Software loads timer three, picks source, then sets run bit 3.
// (RQ7) Timer three control bit 2 makes pin-one edge start the count.
// (RQ8) Timer three divides by n plus one, flags and reloads on underflow.
// (RQ9) Timer four has only load-both; software loads, selects, then runs.
// (RQ10) Timer four divides by n plus one, flags and reloads on underflow.
// (RQ11) Each flag skip-testable; cleared by interrupt taken or by skip.
// (RQ12) Sync zero chosen by timer one control bit 0, enabled by pin control bit 0.
// (RQ13) Pin control bit 1 picks both edges; bit 2 picks rising.
// (RQ14) Sync one uses same edge coding on pin-one control.
// (RQ15) Once set, sync passes count source until enable cleared or reset.
// (RQ16) Watchdog counter counts clocks, pulses at 0000, may clock timer two.
// (RQ17) Kick sets enable flag which never clears; no kick, no supervision. Code clears it on back-up entry and reset.
// (RQ18) Warn flag set when counter reaches BFFF or 3FFF.
// (RQ19) No kick over 32767 counts sets trip flag and drives reset low.
// (RQ20) Software kicks at most every 32766 cycles.
// (RQ21) Back-up entry initialises enable flag, both flags and counter.
// (RQ22) Software kicks just before back-up entry to clear warn flag.
// (RQ23) Timer two source 00 is timer one underflow, 11 watchdog underflow.
// (RQ24) Timers three and four: 00 preceding underflow, 01 prescaler.
// (RQ25) Each underflow is one clock wide pulse.
// (RQ26) Clearing run bit freezes count and reload.
//
// Added by the designer: the strobed register port and the address map.
`default_nettype none
module tcw_top
	import tcw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic backup_i,
	// Register port
	input wire logic [4:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [7:0] rdata_o,
	// Interrupt taken, one bit per timer two to four
	input wire logic [2:0] irq_taken_i,
	// Count sources from outside
	input wire logic t1_uf_i,
	input wire logic prescaler_out_i,
	// External pins
	input wire logic ext_pin_zero_i,
	input wire logic ext_pin_one_i,
	// Timer state
	output logic [2:0] timer_flag_o,
	output logic [2:0] timer_uf_o,
	output logic sync_zero_gate_o,
	// Watchdog
	output logic wdt_uf_o,
	output logic watchdog_enable_o,
	output logic watchdog_warn_o,
	output logic watchdog_trip_o,
	output logic watchdog_reset_n_o
);
	////////////////////////////////////////////////////////////////
	// Control registers
	logic [3:0] first_timer_prescale_ctrl_q, second_timer_ctrl_q;
	logic [3:0] third_timer_ctrl_q, fourth_timer_ctrl_q;
	logic [3:0] pin_zero_edge_ctrl_q, pin_one_edge_ctrl_q;
	logic [7:0] rdata_q, rdata_d;

	// Write decodes
	wire logic wr_ctl_one = we_i & (addr_i == OFS_CTL_ONE);
	wire logic wr_ctl_two = we_i & (addr_i == OFS_CTL_TWO);
	wire logic wr_ctl_three = we_i & (addr_i == OFS_CTL_THREE);
	wire logic wr_ctl_four = we_i & (addr_i == OFS_CTL_FOUR);
	wire logic wr_pin_zero = we_i & (addr_i == OFS_PIN_ZERO);
	wire logic wr_pin_one = we_i & (addr_i == OFS_PIN_ONE);
	wire logic third_timer_load_reload_op = we_i & (addr_i == OFS_T3_RELOAD);
	wire logic watchdog_kick_op = we_i & (addr_i == OFS_WDT);
	wire logic [2:0] load_both_op;
	assign load_both_op[0] = we_i & (addr_i == OFS_T2_BOTH);
	assign load_both_op[1] = we_i & (addr_i == OFS_T3_BOTH); // RQ5
	assign load_both_op[2] = we_i & (addr_i == OFS_T4_BOTH); // RQ9

	// Skip reads test and clear a flag
	wire logic second_flag_skip_op = re_i & (addr_i == OFS_SKIP_T2);
	wire logic third_flag_skip_op = re_i & (addr_i == OFS_SKIP_T3);
	wire logic fourth_flag_skip_op = re_i & (addr_i == OFS_SKIP_T4);

	// Control registers; timer one control is reinitialised on back-up entry
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			first_timer_prescale_ctrl_q <= CTRL_RST;
			second_timer_ctrl_q <= CTRL_RST;
			third_timer_ctrl_q <= CTRL_RST;
			fourth_timer_ctrl_q <= CTRL_RST;
			pin_zero_edge_ctrl_q <= CTRL_RST;
			pin_one_edge_ctrl_q <= CTRL_RST;
		end else begin
			if (backup_i) begin
				first_timer_prescale_ctrl_q <= CTRL_RST;
			end else if (wr_ctl_one) begin
				first_timer_prescale_ctrl_q <= wdata_i[3:0];
			end
			if (wr_ctl_two) begin
				second_timer_ctrl_q <= wdata_i[3:0];
			end
			if (wr_ctl_three) begin
				third_timer_ctrl_q <= wdata_i[3:0];
			end
			if (wr_ctl_four) begin
				fourth_timer_ctrl_q <= wdata_i[3:0];
			end
			if (wr_pin_zero) begin
				pin_zero_edge_ctrl_q <= wdata_i[3:0];
			end
			if (wr_pin_one) begin
				pin_one_edge_ctrl_q <= wdata_i[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Count start synchronisers for timers one and three
	logic [1:0] sync_set;
	wire logic [1:0] sync_pin = {ext_pin_one_i, ext_pin_zero_i};
	wire logic [1:0] sync_sel = {third_timer_ctrl_q[CTL_SYNC_BIT],
		first_timer_prescale_ctrl_q[PRE_SYNC_BIT]};
	wire logic [7:0] sync_ctrl = {pin_one_edge_ctrl_q, pin_zero_edge_ctrl_q};

	genvar gs;
	generate
		for (gs = 0; gs < 2; gs++) begin : g_sync
			tcw_edge_sync u_sync (
				.ref_clk_i(ref_clk_i),
				.rst_n_i(rst_n_i),
				.pin_i(sync_pin[gs]),
				.select_i(sync_sel[gs]),
				.pin_ctrl_i(sync_ctrl[gs*4 +: 4]),
				.set_o(sync_set[gs])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Watchdog counter and flags
	logic [15:0] watchdog_counter_q, wdt_d;
	logic watchdog_enable_flag_q, watchdog_warn_flag_q, watchdog_trip_flag_q;
	logic wdt_uf_q, wdt_rst_n_q;
	wire logic wdt_match = (wdt_d == WDT_MATCH_HI) | (wdt_d == WDT_MATCH_LO);
	// A match with warn still set means a whole half period without a kick
	wire logic trip_now = watchdog_enable_flag_q & wdt_match
		& watchdog_warn_flag_q & ~watchdog_kick_op; // RQ19
	wire logic trip_d = ~backup_i & (watchdog_trip_flag_q | trip_now);

	assign wdt_d = watchdog_counter_q - 16'h0001; // RQ16

	// Free-running down count, set back to FFFF on back-up entry
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			watchdog_counter_q <= WDT_RST;
			wdt_uf_q <= 1'b0;
		end else if (backup_i) begin
			watchdog_counter_q <= WDT_RST; // RQ21
			wdt_uf_q <= 1'b0;
		end else begin
			watchdog_counter_q <= wdt_d;
			wdt_uf_q <= (wdt_d == WDT_ZERO); // RQ16 RQ25
		end
	end

	// Supervision flags
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			watchdog_enable_flag_q <= 1'b0;
			watchdog_warn_flag_q <= 1'b0;
			watchdog_trip_flag_q <= 1'b0;
			wdt_rst_n_q <= 1'b1;
		end else if (backup_i) begin
			watchdog_enable_flag_q <= 1'b0; // RQ21
			watchdog_warn_flag_q <= 1'b0;
			watchdog_trip_flag_q <= 1'b0;
			wdt_rst_n_q <= 1'b1;
		end else begin
			watchdog_enable_flag_q <= watchdog_enable_flag_q | watchdog_kick_op; // RQ17
			if (watchdog_enable_flag_q & wdt_match) begin
				watchdog_warn_flag_q <= 1'b1; // RQ18
			end else if (watchdog_kick_op) begin
				watchdog_warn_flag_q <= 1'b0;
			end
			watchdog_trip_flag_q <= trip_d;
			wdt_rst_n_q <= ~trip_d; // RQ19
		end
	end

	////////////////////////////////////////////////////////////////
	// Timers two to four
	logic [7:0] tmr_count [NUM_TMR];
	logic [7:0] tmr_reload [NUM_TMR];
	logic [2:0] tmr_flag, tmr_uf;
	wire logic [11:0] tmr_ctrl = {fourth_timer_ctrl_q, third_timer_ctrl_q,
		second_timer_ctrl_q};
	// Source vectors indexed by select code; unavailable codes give nothing
	wire logic [11:0] tmr_src = {
		2'b00, prescaler_out_i, tmr_uf[1],          // RQ24
		2'b00, prescaler_out_i, tmr_uf[0],          // RQ24
		wdt_uf_q, 2'b00, t1_uf_i};                  // RQ23
	// Timer three counts only after its pin edge when sync is selected
	wire logic [2:0] tmr_gate = {1'b1,
		~third_timer_ctrl_q[CTL_SYNC_BIT] | sync_set[1], 1'b1}; // RQ7
	wire logic [2:0] tmr_reload_op = {1'b0, third_timer_load_reload_op, 1'b0};
	wire logic [2:0] skip_op = {fourth_flag_skip_op, third_flag_skip_op,
		second_flag_skip_op};
	wire logic [2:0] flag_clr = skip_op | irq_taken_i; // RQ11

	genvar gt;
	generate
		for (gt = 0; gt < NUM_TMR; gt++) begin : g_tmr
			tcw_reload_timer u_tmr ( // RQ8 RQ10
				.ref_clk_i(ref_clk_i),
				.rst_n_i(rst_n_i),
				.run_i(tmr_ctrl[gt*4 + CTL_RUN_BIT]),
				.src_sel_i(tmr_ctrl[gt*4 + CTL_SRC_LSB +: 2]),
				.src_i(tmr_src[gt*4 +: 4]),
				.gate_i(tmr_gate[gt]),
				.load_both_i(load_both_op[gt]),
				.load_reload_i(tmr_reload_op[gt]),
				.data_i(wdata_i),
				.flag_clr_i(flag_clr[gt]),
				.count_o(tmr_count[gt]),
				.reload_o(tmr_reload[gt]),
				.flag_o(tmr_flag[gt]),
				.uf_o(tmr_uf[gt])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Read mux; count reads are meaningful only while stopped
	always_comb begin
		case (addr_i)
			OFS_CTL_ONE: rdata_d = {4'h0, first_timer_prescale_ctrl_q};
			OFS_CTL_TWO: rdata_d = {4'h0, second_timer_ctrl_q};
			OFS_CTL_THREE: rdata_d = {4'h0, third_timer_ctrl_q};
			OFS_CTL_FOUR: rdata_d = {4'h0, fourth_timer_ctrl_q};
			OFS_PIN_ZERO: rdata_d = {4'h0, pin_zero_edge_ctrl_q};
			OFS_PIN_ONE: rdata_d = {4'h0, pin_one_edge_ctrl_q};
			OFS_T2_BOTH: rdata_d = tmr_count[0]; // RQ4
			OFS_T3_BOTH: rdata_d = tmr_count[1];
			OFS_T3_RELOAD: rdata_d = tmr_reload[1];
			OFS_T4_BOTH: rdata_d = tmr_count[2];
			OFS_SKIP_T2: rdata_d = {7'h00, tmr_flag[0]}; // RQ11
			OFS_SKIP_T3: rdata_d = {7'h00, tmr_flag[1]};
			OFS_SKIP_T4: rdata_d = {7'h00, tmr_flag[2]};
			OFS_WDT: rdata_d = {2'h0, sync_set, watchdog_trip_flag_q,
				watchdog_warn_flag_q, watchdog_enable_flag_q, wdt_rst_n_q};
			default: rdata_d = RDATA_RST;
		endcase
	end

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= RDATA_RST;
		end else begin
			rdata_q <= re_i ? rdata_d : RDATA_RST;
		end
	end

	// Outputs
	assign rdata_o = rdata_q;
	assign timer_flag_o = tmr_flag;
	assign timer_uf_o = tmr_uf;
	assign sync_zero_gate_o = sync_set[0]; // RQ15
	assign wdt_uf_o = wdt_uf_q;
	assign watchdog_enable_o = watchdog_enable_flag_q;
	assign watchdog_warn_o = watchdog_warn_flag_q;
	assign watchdog_trip_o = watchdog_trip_flag_q;
	assign watchdog_reset_n_o = wdt_rst_n_q;
endmodule
`default_nettype wire

/* core/tcw_pkg.sv */
`default_nettype none
package tcw_pkg;
	// Register port widths
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned CTRL_W = 4;
	localparam int unsigned TMR_W = 8;
	localparam int unsigned WDT_W = 16;
	localparam int unsigned NUM_TMR = 3;

	// Register and instruction offsets
	localparam logic [4:0] OFS_CTL_ONE = 5'h00;
	localparam logic [4:0] OFS_CTL_TWO = 5'h01;
	localparam logic [4:0] OFS_CTL_THREE = 5'h02;
	localparam logic [4:0] OFS_CTL_FOUR = 5'h03;
	localparam logic [4:0] OFS_PIN_ZERO = 5'h04;
	localparam logic [4:0] OFS_PIN_ONE = 5'h05;
	localparam logic [4:0] OFS_T2_BOTH = 5'h06;
	localparam logic [4:0] OFS_T3_BOTH = 5'h07;
	localparam logic [4:0] OFS_T3_RELOAD = 5'h08;
	localparam logic [4:0] OFS_T4_BOTH = 5'h09;
	localparam logic [4:0] OFS_SKIP_T2 = 5'h0A;
	localparam logic [4:0] OFS_SKIP_T3 = 5'h0B;
	localparam logic [4:0] OFS_SKIP_T4 = 5'h0C;
	localparam logic [4:0] OFS_WDT = 5'h0D;

	// Control field positions
	localparam int unsigned CTL_SRC_LSB = 0;
	localparam int unsigned CTL_SYNC_BIT = 2;
	localparam int unsigned CTL_RUN_BIT = 3;
	localparam int unsigned PRE_SYNC_BIT = 0;
	localparam int unsigned PIN_EN_BIT = 0;
	localparam int unsigned PIN_BOTH_BIT = 1;
	localparam int unsigned PIN_RISE_BIT = 2;

	// Count source codes
	localparam logic [1:0] SRC_CHAIN = 2'h0;
	localparam logic [1:0] SRC_PRESCALE = 2'h1;
	localparam logic [1:0] SRC_WDT = 2'h3;

	// Values after reset
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [7:0] TMR_RST = 8'h00;
	localparam logic [15:0] WDT_RST = 16'hFFFF;
	localparam logic [7:0] RDATA_RST = 8'h00;

	// Watchdog match points
	localparam logic [15:0] WDT_ZERO = 16'h0000;
	localparam logic [15:0] WDT_MATCH_HI = 16'hBFFF;
	localparam logic [15:0] WDT_MATCH_LO = 16'h3FFF;
endpackage
`default_nettype wire

/* core/tcw_reload_timer.sv */
`default_nettype none
module tcw_reload_timer
	import tcw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic run_i,
	input wire logic [1:0] src_sel_i,
	input wire logic [3:0] src_i,
	input wire logic gate_i,
	// Loads
	input wire logic load_both_i,
	input wire logic load_reload_i,
	input wire logic [7:0] data_i,
	input wire logic flag_clr_i,
	// State
	output logic [7:0] count_o,
	output logic [7:0] reload_o,
	output logic flag_o,
	output logic uf_o
);
	logic [7:0] count_q, count_d, reload_q, reload_d;
	logic flag_q, uf_q;
	wire logic tick = run_i & gate_i & src_i[src_sel_i];
	wire logic underflow = tick & (count_q == TMR_RST);

	// Next count: load, reload on underflow, or decrement
	always_comb begin
		count_d = count_q;
		reload_d = reload_q;
		if (load_both_i) begin
			count_d = data_i;
			reload_d = data_i; // RQ5
		end else begin
			if (load_reload_i) begin
				reload_d = data_i; // RQ5
			end
			if (underflow) begin
				count_d = reload_q; // RQ3
			end else if (tick) begin
				count_d = count_q - 8'h01; // RQ2
			end
		end
	end

	// Stopped timer holds its count (RQ26)
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_q <= TMR_RST;
			reload_q <= TMR_RST;
			flag_q <= 1'b0;
			uf_q <= 1'b0;
		end else begin
			count_q <= count_d;
			reload_q <= reload_d;
			flag_q <= underflow | (flag_q & ~flag_clr_i); // RQ11
			uf_q <= underflow; // RQ25
		end
	end

	assign count_o = count_q;
	assign reload_o = reload_q;
	assign flag_o = flag_q;
	assign uf_o = uf_q;
endmodule
`default_nettype wire

/* core/tcw_edge_sync.sv */
`default_nettype none
module tcw_edge_sync
	import tcw_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Pin and control
	input wire logic pin_i,
	input wire logic select_i,
	input wire logic [3:0] pin_ctrl_i,
	// Gate state
	output logic set_o
);
	logic prev_q, set_q;
	wire logic rise = pin_i & ~prev_q;
	wire logic fall = ~pin_i & prev_q;
	wire logic enable = pin_ctrl_i[PIN_EN_BIT];
	wire logic edge_ok = pin_ctrl_i[PIN_BOTH_BIT] ? (rise | fall)
		: (pin_ctrl_i[PIN_RISE_BIT] ? rise : fall); // RQ13 RQ14

	// Latch on a valid edge, drop when the pin enable is cleared
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b0;
			set_q <= 1'b0;
		end else begin
			prev_q <= pin_i;
			set_q <= enable & (set_q | (select_i & edge_ok)); // RQ12 RQ15
		end
	end

	assign set_o = set_q;
endmodule
`default_nettype wire

/* testbench/tcw_chk.sv */
`default_nettype none
module tcw_chk
	import tcw_pkg::*;
(
	// Clock, reset and bus
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	input wire logic backup_i,
	input wire logic [4:0] addr_i,
	input wire logic we_i,
	input wire logic re_i,
	input wire logic [7:0] rdata_o,
	input wire logic [2:0] irq_taken_i,
	// Timer and watchdog state
	input wire logic [2:0] timer_flag_o,
	input wire logic wdt_uf_o,
	input wire logic watchdog_enable_o,
	input wire logic watchdog_warn_o,
	input wire logic watchdog_trip_o,
	input wire logic watchdog_reset_n_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Instruction decodes
	wire logic kick = we_i && addr_i == OFS_WDT;
	wire logic skip3 = re_i && addr_i == OFS_SKIP_T3;
	////////////////////////////////////////
	a_wdt_uf_wide: assert property (wdt_uf_o |=> !wdt_uf_o)
		else $error("watchdog underflow wider than one cycle");
	a_kick_enables: assert property (kick && !backup_i |=> watchdog_enable_o)
		else $error("kick did not arm watchdog");
	a_enable_sticky: assert property (watchdog_enable_o && !backup_i |=> watchdog_enable_o)
		else $error("watchdog enable dropped");
	a_no_kick_idle: assert property (!watchdog_enable_o && !kick |=> !watchdog_enable_o)
		else $error("watchdog armed without kick");
	a_unarmed_quiet: assert property (!watchdog_enable_o |-> !watchdog_warn_o && !watchdog_trip_o)
		else $error("watchdog flag while disarmed");
	a_trip_drives_reset: assert property (watchdog_trip_o |-> !watchdog_reset_n_o)
		else $error("trip without reset request");
	a_warn_before_trip: assert property ($rose(watchdog_trip_o) |-> $past(watchdog_warn_o))
		else $error("trip without earlier warning");
	a_backup_init: assert property (backup_i |=> !watchdog_enable_o ##0 !watchdog_warn_o ##0 !watchdog_trip_o)
		else $error("back-up entry left watchdog state");
	a_skip_reports: assert property (skip3 && timer_flag_o[1] |=> rdata_o[0])
		else $error("skip read lost the flag");
	a_flag_holds: assert property (timer_flag_o[1] && !skip3 && !irq_taken_i[1] |=> timer_flag_o[1])
		else $error("flag cleared without cause");
	a_rdata_idle: assert property (!$past(re_i) |-> rdata_o == RDATA_RST)
		else $error("read data outside read cycle");
endmodule
`default_nettype wire

/* testbench/tcw_src_model.sv */
`default_nettype none
module tcw_src_model
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Burst request
	input wire logic go_i,
	input wire logic sel_i,
	input wire logic [7:0] num_i,
	// Count pulses
	output logic t1_uf_o,
	output logic prescaler_out_o,
	output logic busy_o
);
	logic [7:0] left_q;
	logic sel_q;
	logic ph_q;
	// Burst of one-cycle pulses, every second cycle so no timer sees them merged
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			left_q <= 8'h00;
			sel_q <= 1'b0;
			ph_q <= 1'b0;
			t1_uf_o <= 1'b0;
			prescaler_out_o <= 1'b0;
		end else begin
			t1_uf_o <= 1'b0;
			prescaler_out_o <= 1'b0;
			if (go_i) begin
				left_q <= num_i;
				sel_q <= sel_i;
				ph_q <= 1'b0;
			end else if (left_q != 8'h00) begin
				ph_q <= ~ph_q;
				if (ph_q) begin
					left_q <= left_q - 8'h01;
					t1_uf_o <= ~sel_q;
					prescaler_out_o <= sel_q;
				end
			end
		end
	end
	assign busy_o = left_q != 8'h00;
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import tcw_pkg::*;
	logic ref_clk_i = 1'b0, rst_n_i = 1'b0, backup_i = 1'b0, we_i = 1'b0, re_i = 1'b0;
	logic [4:0] addr_i = 5'h00;
	logic [7:0] wdata_i = 8'h00, rdata_o;
	logic [2:0] irq_taken_i = 3'h0, timer_flag_o, timer_uf_o;
	logic ext_pin_zero_i = 1'b0, ext_pin_one_i = 1'b0, t1_uf_i, prescaler_out_i;
	logic sync_zero_gate_o, wdt_uf_o, watchdog_enable_o, watchdog_warn_o;
	logic watchdog_trip_o, watchdog_reset_n_o, busy, go = 1'b0, sel = 1'b0;
	logic [7:0] num = 8'h00;
	int fails = 0, comparisons = 0, cnt_wdt = 0, n;
	int cnt_uf [3] = '{0, 0, 0};
	always #20 ref_clk_i = ~ref_clk_i;
	tcw_top i_tcw_top (.ref_clk_i, .rst_n_i, .backup_i, .addr_i, .wdata_i, .we_i, .re_i,
		.rdata_o, .irq_taken_i, .t1_uf_i, .prescaler_out_i, .ext_pin_zero_i, .ext_pin_one_i,
		.timer_flag_o, .timer_uf_o, .sync_zero_gate_o, .wdt_uf_o, .watchdog_enable_o,
		.watchdog_warn_o, .watchdog_trip_o, .watchdog_reset_n_o);
	tcw_src_model i_tcw_src_model (.ref_clk_i, .rst_n_i, .go_i(go), .sel_i(sel), .num_i(num),
		.t1_uf_o(t1_uf_i), .prescaler_out_o(prescaler_out_i), .busy_o(busy));
	// Underflow tallies
	always @(posedge ref_clk_i) begin
		for (int k = 0; k < 3; k++) cnt_uf[k] += int'(timer_uf_o[k]);
		cnt_wdt += int'(wdt_uf_o);
	end
	////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic clr();
		@(negedge ref_clk_i);
		cnt_uf = '{0, 0, 0};
		cnt_wdt = 0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		we_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge ref_clk_i);
		we_i <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		@(posedge ref_clk_i);
		re_i <= 1'b1;
		addr_i <= a;
		@(posedge ref_clk_i);
		re_i <= 1'b0;
		@(negedge ref_clk_i);
		chk({8'h00, rdata_o}, {8'h00, e});
	endtask
	// Burst of count pulses from the source model, then let the chain settle
	task automatic burst(input logic s, input logic [7:0] k);
		clr();
		@(posedge ref_clk_i);
		go <= 1'b1;
		sel <= s;
		num <= k;
		@(posedge ref_clk_i);
		go <= 1'b0;
		// Look off the edge so the model's load is already visible
		@(negedge ref_clk_i);
		for (int i = 0; i < 600 && busy; i++) @(negedge ref_clk_i);
		repeat (6) @(posedge ref_clk_i);
	endtask
	task automatic pin(input logic z, input logic v);
		@(posedge ref_clk_i);
		if (z) ext_pin_zero_i <= v;
		else ext_pin_one_i <= v;
		repeat (3) @(posedge ref_clk_i);
	endtask
	task automatic wait_st(input logic trip, input int lim);
		@(negedge ref_clk_i);
		n = 0;
		while (!(trip ? watchdog_trip_o : watchdog_warn_o) && n < lim) begin
			@(posedge ref_clk_i);
			n++;
		end
	endtask
	task automatic kick_wd();
		wr(OFS_WDT, 8'h00);
	endtask
	////////////////////////////////////////
	task automatic t_reset_map();
		for (int a = 0; a < 6; a++) rdc(5'(a), {4'h0, CTRL_RST});
		rdc(OFS_WDT, 8'h01);
		rdc(5'h1F, 8'h00);
	endtask
	task automatic t_chain();
		wr(OFS_T2_BOTH, 8'h01);
		wr(OFS_CTL_TWO, 8'h08);
		wr(OFS_T3_BOTH, 8'h01);
		wr(OFS_CTL_THREE, 8'h08);
		wr(OFS_T4_BOTH, 8'h00);
		wr(OFS_CTL_FOUR, 8'h08);
		burst(1'b0, 8'h10);
		chk(16'(cnt_uf[0]), 16'h0008);
		chk(16'(cnt_uf[1]), 16'h0004);
		chk(16'(cnt_uf[2]), 16'h0004);
		rdc(OFS_SKIP_T3, 8'h01);
		rdc(OFS_SKIP_T3, 8'h00);
		@(posedge ref_clk_i);
		irq_taken_i <= 3'h4;
		@(posedge ref_clk_i);
		irq_taken_i <= 3'h0;
		rdc(OFS_SKIP_T4, 8'h00);
		wr(OFS_CTL_TWO, 8'h00);
		rdc(OFS_T2_BOTH, 8'h01);
		burst(1'b0, 8'h03);
		chk(16'(cnt_uf[0]), 16'h0000);
		rdc(OFS_T2_BOTH, 8'h01);
		wr(OFS_CTL_THREE, 8'h00);
		wr(OFS_CTL_FOUR, 8'h00);
	endtask
	task automatic t_prescale();
		wr(OFS_T3_BOTH, 8'h01);
		wr(OFS_T3_RELOAD, 8'h04);
		rdc(OFS_T3_RELOAD, 8'h04);
		wr(OFS_T4_BOTH, 8'h02);
		wr(OFS_CTL_THREE, 8'h09);
		wr(OFS_CTL_FOUR, 8'h09);
		burst(1'b1, 8'h09);
		chk(16'(cnt_uf[1]), 16'h0002);
		chk(16'(cnt_uf[2]), 16'h0003);
		wr(OFS_CTL_THREE, 8'h00);
		wr(OFS_CTL_FOUR, 8'h00);
	endtask
	task automatic t_sync();
		wr(OFS_T3_BOTH, 8'h00);
		wr(OFS_PIN_ONE, 8'h05);
		wr(OFS_CTL_THREE, 8'h0D);
		burst(1'b1, 8'h04);
		chk(16'(cnt_uf[1]), 16'h0000);
		pin(1'b0, 1'b1);
		burst(1'b1, 8'h04);
		chk(16'(cnt_uf[1]), 16'h0004);
		wr(OFS_PIN_ONE, 8'h04);
		burst(1'b1, 8'h04);
		chk(16'(cnt_uf[1]), 16'h0000);
		wr(OFS_CTL_THREE, 8'h00);
		wr(OFS_CTL_ONE, 8'h01);
		wr(OFS_PIN_ZERO, 8'h01);
		pin(1'b1, 1'b1);
		chk(16'(sync_zero_gate_o), 16'h0000);
		pin(1'b1, 1'b0);
		chk(16'(sync_zero_gate_o), 16'h0001);
		wr(OFS_PIN_ZERO, 8'h00);
		repeat (2) @(posedge ref_clk_i);
		chk(16'(sync_zero_gate_o), 16'h0000);
		wr(OFS_PIN_ZERO, 8'h03);
		pin(1'b1, 1'b1);
		chk(16'(sync_zero_gate_o), 16'h0001);
	endtask
	task automatic t_watchdog();
		wr(OFS_T2_BOTH, 8'h00);
		wr(OFS_CTL_TWO, 8'h0B);
		@(posedge ref_clk_i);
		backup_i <= 1'b1;
		@(posedge ref_clk_i);
		backup_i <= 1'b0;
		clr();
		kick_wd();
		wait_st(1'b0, 17000);
		chk(16'(n > 16370 && n < 16390), 16'h0001);
		kick_wd();
		@(negedge ref_clk_i);
		chk(16'({watchdog_warn_o, watchdog_enable_o}), 16'h0001);
		wait_st(1'b0, 33000);
		chk(16'(n > 32750 && n < 32780), 16'h0001);
		chk(16'(watchdog_trip_o), 16'h0000);
		wait_st(1'b1, 33000);
		chk(16'(n > 32750 && n < 32780), 16'h0001);
		chk(16'(watchdog_reset_n_o), 16'h0000);
		chk(16'(cnt_wdt), 16'h0001);
		chk(16'(cnt_uf[0]), 16'h0001);
		kick_wd();
		@(posedge ref_clk_i);
		backup_i <= 1'b1;
		@(posedge ref_clk_i);
		backup_i <= 1'b0;
		@(negedge ref_clk_i);
		chk(16'({watchdog_trip_o, watchdog_warn_o, watchdog_enable_o}), 16'h0000);
	endtask
	task automatic close_out();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		t_reset_map();
		t_chain();
		t_prescale();
		t_sync();
		t_watchdog();
		close_out();
	end
	// Watchdog: the run needs about 82000 cycles
	initial begin
		#(95000 * 40);
		fails++;
		close_out();
	end
endmodule
bind tcw_top tcw_chk i_tcw_chk (.ref_clk_i, .rst_n_i, .backup_i, .addr_i, .we_i, .re_i,
	.rdata_o, .irq_taken_i, .timer_flag_o, .wdt_uf_o, .watchdog_enable_o, .watchdog_warn_o,
	.watchdog_trip_o, .watchdog_reset_n_o);
`default_nettype wire
